// ### pkg/pd_irq_consts.svh
// register offsets, field positions and reset values of the interrupt and wake block
`ifndef PD_IRQ_CONSTS_SVH
`define PD_IRQ_CONSTS_SVH
`define OFS_PWR_WAKE_STAT  16'h1A84
`define OFS_SOP_STAT       16'h1A85
`define OFS_TX_EN          16'h1A86
`define OFS_RX_EN          16'h1A87
`define OFS_RX_ERR_EN      16'h1A88
`define OFS_PWR_WAKE_EN    16'h1A89
`define OFS_SOP_EN         16'h1A8A
`define BIT_WAKE_STAT      0
`define BIT_WAKE_EN        0
`define BIT_START_EN       2
`define BIT_STOP_EN        3
`define BIT_RX_RSVD        4
`define RX_EN_MASK         8'hEF
`define RX_ERR_EN_MASK     8'h8F
`define RST_EN8            8'h00
`define RST_SOP5           5'h00
`endif

// ### pkg/pd_irq_pkg.sv
// types shared by the interrupt and wake block
package pd_irq_pkg;
    // register port request from software
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic        wr;
        logic        rd;
    } reg_req_t;

    // state of the block apart from the two rx_line toggles, one flop set
    typedef struct packed {
        logic [7:0] tx_en;
        logic [7:0] rx_en;
        logic [7:0] rx_err_en;
        logic [4:0] sop_en;
        logic       wake_en;
        logic       start_en;
        logic       stop_en;
        logic [4:0] sop_flags;
        logic       wake_ack;
        logic       start_ack;
        logic       sq_s1;
        logic       sq_s2;
        logic       wt_s1;
        logic       wt_s2;
        logic       at_s1;
        logic       at_s2;
        logic [7:0] rdata;
    } irq_state_t;
endpackage : pd_irq_pkg

// ### hw/pd_mac_irq_wake_control.sv
// interrupt status, enables, activity wake and clock request logic of the pd mac
//
// Summary of operation
// - wake flag sets on receive line, clockless
// - wake flag never sets while disabled
// - wake flag ignores clock request enables
// - frame start types recorded regardless of filter
// - five frame start flags, reset zero
// - frame start flags drive own interrupt
// - hardware sets flags, write one clears
// - transmit, receive, error and frame start enables gate interrupt only, not recording
// - all enables zero after reset
// - transmit enable bit layout
// - receive enable layout, bit four reserved
// - receive error enable layout, 6:4 reserved
// - stop enable requests clock stop when idle
// - idle mac drops clock need unless squelch is seen
// - start enable requests clock on activity
// - squelch always needs clock once running
// - clock enables never affect wake interrupt
// - power enable bit zero, reserved bits
`include "pd_irq_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module pd_mac_irq_wake_control
    import pd_irq_pkg::*;
(
    // clock, reset and freeze
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    input  wire logic       clk_en,
    // register port
    input  wire reg_req_t   reg_req,
    output var  logic [7:0] reg_rdata,
    // pins: receive line and squelch detector
    input  wire logic       rx_line,
    input  wire logic       squelch_pin,
    // packet engine, same clock
    input  wire logic [4:0] frame_start_type_flags,
    input  wire logic [7:0] tx_irq_flags,
    input  wire logic [7:0] rx_irq_flags,
    input  wire logic [7:0] rx_err_irq_flags,
    input  wire logic       mac_idle,
    // interrupt outputs
    output var  logic       tx_irq,
    output var  logic       rx_irq,
    output var  logic       rx_err_irq,
    output var  logic       sop_irq,
    output var  logic       pm_irq,
    // clock requests
    output var  logic       clock_start_request,
    output var  logic       clock_stop_request,
    output var  logic       clock_needed
);

    irq_state_t st;
    irq_state_t next_st;
    logic       wake_tgl;
    logic       act_tgl;
    logic       wake_status;
    logic       wr_hit;
    logic       rd_go;

    // ************************************************
    // clockless activity capture
    // ************************************************

    // rx line edge is its own clock, so wake is caught with core_clk stopped
    // clockless wake capture
    // gated by wake enable
    // a pending flag blocks further toggles, else a second edge would hide it;
    // the ack is read unsynchronised, safe only while clocks are meant to stop
    always_ff @(posedge rx_line or negedge rst_n) begin
        if (!rst_n) begin
            wake_tgl <= 1'b0;
        end else if (st.wake_en && (wake_tgl == st.wake_ack)) begin
            wake_tgl <= ~wake_tgl;
        end
    end

    // activity seen for the start request, independent of the wake enable
    // an unacknowledged request is not toggled away by a second edge
    always_ff @(posedge rx_line or negedge rst_n) begin
        if (!rst_n) begin
            act_tgl <= 1'b0;
        end else if (act_tgl == st.start_ack) begin
            act_tgl <= ~act_tgl;
        end
    end

    // ************************************************
    // next state
    // ************************************************

    assign wr_hit = reg_req.wr & clk_en;
    assign rd_go  = reg_req.rd & clk_en;

    // one process decides every core_clk register update
    always_comb begin
        next_st = st;
        // two flops on every crossing into core_clk; first stage feeds only the second
        next_st.sq_s1 = squelch_pin;
        next_st.sq_s2 = st.sq_s1;
        next_st.wt_s1 = wake_tgl;
        next_st.wt_s2 = st.wt_s1;
        next_st.at_s1 = act_tgl;
        next_st.at_s2 = st.at_s1;
        if (st.sq_s2) begin
            next_st.start_ack = st.at_s2;
        end
        next_st.sop_flags = st.sop_flags | frame_start_type_flags;
        if (wr_hit) begin
            unique case (reg_req.addr)
                `OFS_PWR_WAKE_STAT: begin
                    // ack only what has crossed; a fresh edge stays pending
                    if (reg_req.wdata[`BIT_WAKE_STAT]) begin
                        next_st.wake_ack = st.wt_s2;
                    end
                end
                `OFS_SOP_STAT: begin
                    next_st.sop_flags = (st.sop_flags & ~reg_req.wdata[4:0])
                                      | frame_start_type_flags;
                end
                `OFS_TX_EN: begin
                    next_st.tx_en = reg_req.wdata;
                end
                `OFS_RX_EN: begin
                    next_st.rx_en = reg_req.wdata & `RX_EN_MASK;
                end
                `OFS_RX_ERR_EN: begin
                    next_st.rx_err_en = reg_req.wdata & `RX_ERR_EN_MASK;
                end
                // only bits 0, 2 and 3 stored
                `OFS_PWR_WAKE_EN: begin
                    next_st.wake_en  = reg_req.wdata[`BIT_WAKE_EN];
                    next_st.start_en = reg_req.wdata[`BIT_START_EN];
                    next_st.stop_en  = reg_req.wdata[`BIT_STOP_EN];
                end
                `OFS_SOP_EN: begin
                    next_st.sop_en = reg_req.wdata[4:0];
                end
                default: begin
                    // unmapped writes are dropped
                end
            endcase
        end
        // read data valid the cycle after the strobe, zero otherwise
        next_st.rdata = 8'h00;
        if (rd_go) begin
            unique case (reg_req.addr)
                `OFS_PWR_WAKE_STAT: next_st.rdata = {7'h00, wake_status};
                // five flags, upper bits read zero
                `OFS_SOP_STAT:      next_st.rdata = {3'h0, st.sop_flags};
                `OFS_TX_EN:         next_st.rdata = st.tx_en;
                `OFS_RX_EN:         next_st.rdata = st.rx_en;
                `OFS_RX_ERR_EN:     next_st.rdata = st.rx_err_en;
                `OFS_PWR_WAKE_EN:   next_st.rdata = {4'h0, st.stop_en,
                                                     st.start_en, 1'b0,
                                                     st.wake_en};
                `OFS_SOP_EN:        next_st.rdata = {3'h0, st.sop_en};
                default:            next_st.rdata = 8'h00;
            endcase
        end
    end

    // ************************************************
    // state register
    // ************************************************

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st           <= '0;
            st.tx_en     <= `RST_EN8;
            st.rx_en     <= `RST_EN8;
            st.rx_err_en <= `RST_EN8;
            st.sop_en    <= `RST_SOP5;
        end else if (clk_en) begin
            st <= next_st;
        end
    end

    // ************************************************
    // outputs
    // ************************************************

    // wake status from toggles only, no clock enables
    assign wake_status = st.wt_s2 ^ st.wake_ack;
    assign reg_rdata   = st.rdata;

    assign tx_irq     = |(tx_irq_flags & st.tx_en);
    assign rx_irq     = |(rx_irq_flags & st.rx_en);
    assign rx_err_irq = |(rx_err_irq_flags & st.rx_err_en);
    assign sop_irq    = |(st.sop_flags & st.sop_en);
    assign pm_irq     = wake_status & st.wake_en;

    // raw toggle compare so the request works with no clock
    assign clock_start_request = st.start_en & (act_tgl ^ st.start_ack);
    // stop request needs idle and the enable
    assign clock_stop_request  = st.stop_en & mac_idle;
    // idle drops need; squelch forces it
    assign clock_needed        = st.sq_s2 | ~mac_idle;

    // ************************************************
    // assertions
    // ************************************************

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    sequence s_sop_pulse;
        clk_en && frame_start_type_flags[0];
    endsequence

    sequence s_sop_clear;
        wr_hit && reg_req.addr == `OFS_SOP_STAT && reg_req.wdata[0]
            && !frame_start_type_flags[0];
    endsequence

    sequence s_squelch_held;
        (clk_en && squelch_pin) [*3];
    endsequence

    a_sop_records: assert property (
        s_sop_pulse |=> st.sop_flags[0])
        else $error("frame start flag not set");

    a_sop_w1c: assert property (
        s_sop_clear |=> !st.sop_flags[0])
        else $error("frame start flag not cleared");

    a_sop_hold: assert property (
        st.sop_flags[0] && !(wr_hit && reg_req.addr == `OFS_SOP_STAT)
            |=> st.sop_flags[0])
        else $error("frame start flag lost without clear");

    a_sop_irq_out: assert property (
        st.sop_flags[1] && st.sop_en[1] |-> sop_irq)
        else $error("frame start interrupt missing");

    a_enable_reset: assert property (
        $rose(rst_n) |-> st.tx_en == 8'h00 && st.sop_en == 5'h00)
        else $error("enables not zero after reset");

    a_tx_read: assert property (
        rd_go && reg_req.addr == `OFS_TX_EN |=> reg_rdata == $past(st.tx_en))
        else $error("transmit enable read mismatch");

    a_rx_reserved: assert property (
        rd_go && reg_req.addr == `OFS_RX_EN |=> !reg_rdata[`BIT_RX_RSVD])
        else $error("receive reserved bit nonzero");

    a_pm_reserved: assert property (
        rd_go && reg_req.addr == `OFS_PWR_WAKE_EN |=> reg_rdata[7:4] == 4'h0
            && !reg_rdata[1])
        else $error("power enable reserved bits nonzero");

    a_stop_request: assert property (
        st.stop_en && mac_idle |-> clock_stop_request)
        else $error("idle stop request missing");

    a_squelch_need: assert property (
        s_squelch_held |=> clock_needed)
        else $error("clock need missing under squelch");

    a_idle_release: assert property (
        mac_idle && !st.sq_s2 |-> !clock_needed)
        else $error("idle mac still needs clock");

    a_wake_blocked: assert property (
        !st.wake_en && $stable(wake_tgl) && !wake_status
            ##1 !st.wake_en && $stable(wake_tgl) |-> !wake_status)
        else $error("wake set while disabled");

    a_group_level: assert property (
        |(rx_err_irq_flags & st.rx_err_en) |-> rx_err_irq)
        else $error("receive error interrupt missing");

    // ************************************************
    // further checks: clears, freeze and clock requests
    // ************************************************

    sequence s_wake_clear;
        wr_hit && reg_req.addr == `OFS_PWR_WAKE_STAT && reg_req.wdata[`BIT_WAKE_STAT];
    endsequence

    sequence s_sop_race;
        wr_hit && reg_req.addr == `OFS_SOP_STAT && reg_req.wdata[0]
            && frame_start_type_flags[0];
    endsequence

    // set beats clear in one cycle
    a_sop_set_wins: assert property (
        s_sop_race |=> st.sop_flags[0])
        else $error("frame start set lost to clear");

    // clear of a settled wake flag
    a_wake_clear: assert property (
        s_wake_clear ##0 (st.wt_s1 == st.wt_s2) |=> !wake_status)
        else $error("wake flag not cleared");

    a_wake_sticky: assert property (
        wake_status && !(wr_hit && reg_req.addr == `OFS_PWR_WAKE_STAT)
            |=> wake_status)
        else $error("wake flag dropped without clear");

    // start request stands until squelch acks it
    a_start_hold: assert property (
        clock_start_request && !st.sq_s2 && !(wr_hit && reg_req.addr == `OFS_PWR_WAKE_EN)
            |=> clock_start_request)
        else $error("start request dropped before squelch");

    // stop request only with enable and idle
    a_stop_gated: assert property (
        clock_stop_request |-> st.stop_en && mac_idle)
        else $error("stop request without enable and idle");

    // busy mac always needs the clock
    a_busy_need: assert property (
        !mac_idle |-> clock_needed)
        else $error("busy mac released the clock");

    // wake interrupt only with its enable
    a_pm_gate: assert property (
        pm_irq |-> st.wake_en && wake_status)
        else $error("wake interrupt without enable");

    // frame start interrupt silent with enables off
    a_sop_irq_off: assert property (
        st.sop_en == 5'h00 |-> !sop_irq)
        else $error("frame start interrupt with enables off");

    // reserved error enable field reads zero
    a_err_reserved: assert property (
        rd_go && reg_req.addr == `OFS_RX_ERR_EN |=> reg_rdata[6:4] == 3'h0)
        else $error("receive error reserved bits nonzero");

    // frame start status upper bits read zero
    a_sop_upper: assert property (
        rd_go && reg_req.addr == `OFS_SOP_STAT |=> reg_rdata[7:5] == 3'h0)
        else $error("frame start status upper bits nonzero");

    // highest frame start type recorded too
    a_sop_top_type: assert property (
        clk_en && frame_start_type_flags[4] |=> st.sop_flags[4])
        else $error("last frame start flag not set");

    // flags and other enables clear at reset
    a_flags_reset: assert property (
        $rose(rst_n) |-> st.sop_flags == 5'h00 && st.rx_en == 8'h00 && st.rx_err_en == 8'h00)
        else $error("flags or enables not zero after reset");

    // frozen clock enable holds every flag and enable
    a_freeze_hold: assert property (
        !clk_en |=> st == $past(st))
        else $error("state moved with clock enable low");

    // read data stands one cycle only
    a_rdata_idle: assert property (
        clk_en && !reg_req.rd |=> reg_rdata == 8'h00)
        else $error("read data outlived its cycle");

endmodule : pd_mac_irq_wake_control

`default_nettype wire

// ### verif/pd_line_model.sv
// far-side line model: one receive activity burst with squelch following it
`timescale 1ns/1ps
`default_nettype none

module pd_line_model (
    // clock and burst command
    input  wire logic       core_clk,
    input  wire logic       go,
    input  wire logic [3:0] lag,
    // receive pins
    output var  logic       rx_line,
    output var  logic       squelch_pin
);
    logic [4:0] cnt = 5'h00;

    initial rx_line = 1'b0;
    initial squelch_pin = 1'b0;

    // line rises first, squelch after lag cycles; a late squelch stretches the clockless wake window
    always @(posedge core_clk) begin
        if (go) begin
            rx_line <= 1'b1;
            cnt     <= 5'h01;
        end else if (cnt != 5'h00) begin
            cnt <= cnt + 5'h01;
            if (cnt == {1'b0, lag})
                squelch_pin <= 1'b1;
            if (cnt == {1'b0, lag} + 5'h08) begin
                rx_line     <= 1'b0;
                squelch_pin <= 1'b0;
                cnt         <= 5'h00;
            end
        end
    end
endmodule : pd_line_model
`default_nettype wire

// ### verif/pd_mac_irq_wake_control_bench.sv
// self-checking bench of the interrupt and wake block
`include "pd_irq_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module pd_mac_irq_wake_control_bench import pd_irq_pkg::*;;
    logic       core_clk = 1'b0;
    logic       rst_n, clk_en, go, mac_idle, squelch_pin, rx_line;
    logic       tx_irq, rx_irq, rx_err_irq, sop_irq, pm_irq, c_start, c_stop, c_need;
    reg_req_t   req;
    logic [4:0] sop_in;
    logic [3:0] lag;
    logic [7:0] txf, rxf, erf, rdata, en_tx, en_rx, en_er;
    int         n_errors = 0, n_checks = 0, cyc = 0, i;

    pd_mac_irq_wake_control dut (.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en), .reg_req(req),
        .reg_rdata(rdata), .rx_line(rx_line), .squelch_pin(squelch_pin), .frame_start_type_flags(sop_in),
        .tx_irq_flags(txf), .rx_irq_flags(rxf), .rx_err_irq_flags(erf), .mac_idle(mac_idle),
        .tx_irq(tx_irq), .rx_irq(rx_irq), .rx_err_irq(rx_err_irq), .sop_irq(sop_irq), .pm_irq(pm_irq),
        .clock_start_request(c_start), .clock_stop_request(c_stop), .clock_needed(c_need));
    pd_line_model line (.core_clk(core_clk), .go(go), .lag(lag), .rx_line(rx_line), .squelch_pin(squelch_pin));

    always #20 core_clk = ~core_clk;

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [7:0] rmask(input logic [15:0] a);
        case (a)
            `OFS_TX_EN:       return 8'hFF;
            `OFS_RX_EN:       return `RX_EN_MASK;
            `OFS_RX_ERR_EN:   return `RX_ERR_EN_MASK;
            `OFS_PWR_WAKE_EN: return 8'h0D;
            `OFS_SOP_EN:      return 8'h1F;
            default:          return 8'h00;
        endcase
    endfunction : rmask

    function automatic logic [7:0] grp(input logic [7:0] f, input logic [7:0] e);
        return {7'h00, |(f & e)};
    endfunction : grp

    task automatic close_out;
        if (n_errors == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : close_out

    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge core_clk);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk);
        req.wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [15:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk);
        req.rd <= 1'b0;
        #1 chk("reg_rdata", exp, rdata);
    endtask : rd

    // one activity burst; long enough for the slowest squelch lag to finish
    task automatic burst;
        lag <= 4'($urandom_range(9, 1));
        @(posedge core_clk);
        go <= 1'b1;
        @(posedge core_clk);
        go <= 1'b0;
        repeat (20) @(posedge core_clk);
    endtask : burst

    // hang guard, far above the few hundred cycles the run needs
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_errors++;
            close_out();
        end
    end

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        {rst_n, go, sop_in, txf, rxf, erf} = '0;
        {clk_en, mac_idle, lag, req} = {1'b1, 1'b1, 4'h3, 26'h0};
        void'($urandom(32'hCC2AE6B9));
        repeat (16) @(posedge core_clk);
        rst_n <= 1'b1;
        for (i = 0; i < 8; i++)
            rd(16'h1A84 + 16'(i), 8'h00);
        for (i = 0; i < 8; i++) begin
            wr(16'h1A86 + 16'(i), 8'hFF);
            rd(16'h1A86 + 16'(i), rmask(16'h1A86 + 16'(i)));
        end
        // group levels; first pass has enables off, first two set only the reserved receive and receive error bits
        for (i = 0; i < 40; i++) begin
            en_tx = (i == 0) ? 8'h00 : 8'($urandom);
            en_rx = (i < 2) ? 8'h10 : 8'($urandom);
            en_er = (i < 2) ? 8'h70 : 8'($urandom);
            wr(`OFS_TX_EN, en_tx);
            wr(`OFS_RX_EN, en_rx);
            wr(`OFS_RX_ERR_EN, en_er);
            txf <= (i < 2) ? 8'hFF : 8'($urandom);
            rxf <= (i < 2) ? 8'hFF : 8'($urandom);
            erf <= (i < 2) ? 8'hFF : 8'($urandom);
            @(posedge core_clk);
            #1 chk("tx_irq", grp(txf, en_tx), 8'(tx_irq));
            chk("rx_irq", grp(rxf, en_rx & `RX_EN_MASK), 8'(rx_irq));
            chk("rx_err_irq", grp(erf, en_er & `RX_ERR_EN_MASK), 8'(rx_err_irq));
        end
        // a write with the clock enable low must not land
        clk_en <= 1'b0;
        wr(`OFS_TX_EN, ~en_tx);
        clk_en <= 1'b1;
        rd(`OFS_TX_EN, en_tx);
        // each frame start type records while its enable is off
        wr(`OFS_SOP_EN, 8'h00);
        for (i = 0; i < 5; i++) begin
            sop_in <= 5'(1 << i);
            @(posedge core_clk);
            sop_in <= 5'h00;
            @(posedge core_clk);
            #1 chk("sop_irq", 8'h00, 8'(sop_irq));
            wr(`OFS_SOP_STAT, 8'h00);
            rd(`OFS_SOP_STAT, 8'(1 << i));
            wr(`OFS_SOP_EN, 8'(1 << i));
            #1 chk("sop_irq", 8'h01, 8'(sop_irq));
            wr(`OFS_SOP_STAT, 8'hFF);
            rd(`OFS_SOP_STAT, 8'h00);
        end
        // a new frame start in the same cycle as its clear must survive
        @(posedge core_clk);
        sop_in <= 5'h01;
        req    <= '{addr: `OFS_SOP_STAT, wdata: 8'hFF, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk);
        sop_in <= 5'h00;
        req.wr <= 1'b0;
        rd(`OFS_SOP_STAT, 8'h01);
        wr(`OFS_SOP_STAT, 8'hFF);
        // clock requests while idle, then on activity
        wr(`OFS_PWR_WAKE_EN, 8'h0C);
        #1 chk("clock_stop_request", 8'h01, 8'(c_stop));
        chk("clock_needed", 8'h00, 8'(c_need));
        go <= 1'b1;
        @(posedge core_clk);
        go <= 1'b0;
        @(posedge core_clk);
        #1 chk("clock_start_request", 8'h01, 8'(c_start));
        wr(`OFS_PWR_WAKE_EN, 8'h00);
        repeat (4) @(posedge core_clk);
        #1 chk("clock_needed", 8'h01, 8'(c_need));
        chk("clock_stop_request", 8'h00, 8'(c_stop));
        repeat (12) @(posedge core_clk);
        rd(`OFS_PWR_WAKE_STAT, 8'h00);
        // wake armed alone, clock request enables left off
        wr(`OFS_PWR_WAKE_EN, 8'h01);
        burst();
        rd(`OFS_PWR_WAKE_STAT, 8'h01);
        #1 chk("pm_irq", 8'h01, 8'(pm_irq));
        // a second burst while the flag is pending must not hide it
        burst();
        rd(`OFS_PWR_WAKE_STAT, 8'h01);
        wr(`OFS_PWR_WAKE_STAT, 8'h00);
        rd(`OFS_PWR_WAKE_STAT, 8'h01);
        wr(`OFS_PWR_WAKE_STAT, 8'h01);
        rd(`OFS_PWR_WAKE_STAT, 8'h00);
        wr(`OFS_PWR_WAKE_EN, 8'h00);
        burst();
        rd(`OFS_PWR_WAKE_STAT, 8'h00);
        // mid-run reset clears every enable again
        rst_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        rd(`OFS_TX_EN, 8'h00);
        rd(`OFS_PWR_WAKE_EN, 8'h00);
        mac_idle <= 1'b0;
        @(posedge core_clk);
        #1 chk("clock_needed", 8'h01, 8'(c_need));
        close_out();
    end
endmodule : pd_mac_irq_wake_control_bench
`default_nettype wire
